/* File: hw/spsdr_cfg.svh */
// Offsets, field positions, reset values and timing counts of the port
`ifndef SPSDR_CFG_SVH
`define SPSDR_CFG_SVH
`define SPSDR_CMD_LAST 5'h07
`define SPSDR_CMD_WEN_BIT 7
`define SPSDR_CMD_RD_BIT 6
`define SPSDR_CTL_W 16
`define SPSDR_DATA_W 24
`define SPSDR_CTL_LAST 5'h0F
`define SPSDR_DATA_LAST 5'h17
`define SPSDR_REG_STATUS 3'h0
`define SPSDR_REG_MODE 3'h1
`define SPSDR_REG_DATA 3'h4
`define SPSDR_NREGS 8
`define SPSDR_CTL_RST 16'h0000
`define SPSDR_CLKSEL_LSB 2
`define SPSDR_FIFO_DEPTH 8
`define SPSDR_CLK_NS 100
`define SPSDR_OSC_HALF_NS 400
`define SPSDR_OSC_HALF_CYC \
  ((`SPSDR_OSC_HALF_NS + `SPSDR_CLK_NS - 1) / `SPSDR_CLK_NS)
`endif

/* File: hw/spsdr_pkg.sv */
// Types shared by the serial port with data ready
package spsdr_pkg;
  // Clock source choices, in field order
  typedef enum logic [1:0] {
    CLK_INT, CLK_INT_OUT, CLK_EXT, CLK_XTAL
  } spsdr_clksrc_e;
  // Serial transfer phases
  typedef enum logic [1:0] {ST_CMD, ST_WR, ST_RD} spsdr_state_e;
  // Communications byte
  typedef struct packed {
    logic wen_b;
    logic rd;
    logic [5:0] target_register_field;
  } spsdr_cmd_s;
  // One conversion result
  typedef struct packed {
    logic [23:0] data;
  } spsdr_conv_s;
endpackage : spsdr_pkg

/* File: hw/spsdr_top.sv */
// Serial host port with data ready, clock select and result FIFO
// How it works
// [R1] Four clock sources picked by select field
// [R2] Output changes on falling serial clock edge
// [R3] Output released while chip select is high
// [R4] Idle selected output low means result ready
// [R5] Unread ready returns high before next update
// [R6] Read shift register loads the addressed register
// [R7] Input bit captured on rising serial clock
// [R8] Written word goes to addressed control register
// [R9] Works with chip select tied low
`timescale 1ns/1ps
`include "spsdr_cfg.svh"

// Result buffer between converter and data register
module spsdr_fifo #(
  parameter int W = 24,
  parameter int DEPTH = 8
) (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH]; // Storage words
  logic [AW-1:0] wr_q; // Write index
  logic [AW-1:0] rd_q; // Read index
  logic [AW:0] cnt_q; // Words held
  logic push;
  logic pop;

  assign in_ready_o = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_q != '0);
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;
  assign out_data_o = mem[rd_q];

  // Pointers and fill level
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      // Wrap by hand so depth need not be a power of two
      if (push) wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      if (pop) rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      if (push && !pop) cnt_q <= cnt_q + 1'b1;
      else if (pop && !push) cnt_q <= cnt_q - 1'b1;
    end
  end

  // Storage has no reset; contents are qualified by the level
  always_ff @(posedge core_clk_i) begin
    if (push) mem[wr_q] <= in_data_i;
  end
endmodule : spsdr_fifo

module spsdr_top (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic sclk_i,
  input wire logic cs_b_i,
  input wire logic din_i,
  output logic dout_rdy_o,
  output logic dout_rdy_oe_o,
  input wire logic clock_io_pin_i,
  output logic clock_io_pin_o,
  output logic clock_io_pin_oe_o,
  output logic crystal_enable_o,
  output spsdr_pkg::spsdr_clksrc_e clock_source_select_o,
  output logic ext_clk_tick_o,
  input wire logic conv_valid_i,
  output logic conv_ready_o,
  input wire spsdr_pkg::spsdr_conv_s conv_i
);
  // Pin synchronisers: stage 1 feeds stage 2 only
  logic [1:0] sclk_s; // Serial clock sync
  logic [1:0] cs_s; // Select sync
  logic [1:0] din_s; // Data in sync
  logic [1:0] cio_s; // Clock pin sync
  logic sclk_d1_q; // Last serial clock level
  logic cio_d1_q; // Last clock pin level
  logic sclk_rise;
  logic sclk_fall;
  logic cs_act; // Port selected

  // Serial engine state
  spsdr_pkg::spsdr_state_e st_q; // Transfer phase
  logic [4:0] cnt_q; // Bit count in phase
  logic [23:0] sh_in_q; // Input shift register
  logic [23:0] sh_out_q; // Output shift register
  spsdr_pkg::spsdr_cmd_s cmd_q; // Latched command
  spsdr_pkg::spsdr_cmd_s cmd_w; // Command being completed
  logic [15:0] regs_q [`SPSDR_NREGS]; // Control registers
  logic [23:0] data_q; // Data register
  logic rdy_b_q; // Ready, active low
  logic blank_q; // Update pending
  logic dout_q; // Output pin flop
  logic rd_end; // Last bit of a read
  logic wr_end; // Last bit of a write
  logic [23:0] rd_mux; // Word a read would load now

  // Clock select state
  logic [7:0] osc_cnt_q; // Oscillator half period
  logic osc_q; // Internal oscillator model

  // Result buffer outputs
  logic fifo_valid;
  logic fifo_ready;
  spsdr_pkg::spsdr_conv_s fifo_data;

  // Word a read places into the output shift register
  function automatic logic [23:0] rd_word(input logic [2:0] ra);
    if (ra == `SPSDR_REG_DATA) return data_q;
    if (ra == `SPSDR_REG_STATUS) return {rdy_b_q, 23'h000000};
    return {regs_q[ra], 8'h00};
  endfunction : rd_word

  // Last bit index of a read from this register
  function automatic logic [4:0] last_bit(input logic [2:0] ra);
    return (ra == `SPSDR_REG_DATA) ? `SPSDR_DATA_LAST : `SPSDR_CTL_LAST;
  endfunction : last_bit

  assign cmd_w = {sh_in_q[6:0], din_s[1]};
  // A process, not an assign, so it also wakes on what rd_word reads
  always_comb rd_mux = rd_word(cmd_w.target_register_field[2:0]);
  assign sclk_rise = sclk_s[1] & ~sclk_d1_q;
  assign sclk_fall = ~sclk_s[1] & sclk_d1_q;
  assign cs_act = ~cs_s[1];
  assign rd_end = sclk_rise && (st_q == spsdr_pkg::ST_RD) &&
                  (cnt_q == last_bit(cmd_q.target_register_field[2:0]));
  assign wr_end = sclk_rise && (st_q == spsdr_pkg::ST_WR) &&
                  (cnt_q == `SPSDR_CTL_LAST);

  // Two-flop synchronisers and edge history
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sclk_s <= 2'h3; // Idle high, so no false rise after reset
      cs_s <= 2'h3;
      din_s <= 2'h0;
      cio_s <= 2'h0;
      sclk_d1_q <= 1'b1; // Matches the synced idle level
      cio_d1_q <= 1'b0;
    end else begin
      sclk_s <= {sclk_s[0], sclk_i};
      cs_s <= {cs_s[0], cs_b_i};
      din_s <= {din_s[0], din_i};
      cio_s <= {cio_s[0], clock_io_pin_i};
      sclk_d1_q <= sclk_s[1];
      cio_d1_q <= cio_s[1];
    end
  end

  // Serial transfer engine; a tied-low select relies on bit counts
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_q <= spsdr_pkg::ST_CMD;
      cnt_q <= 5'h00;
      sh_in_q <= 24'h000000;
      cmd_q <= '0;
    end else if (!cs_act) begin
      // Deselect aborts any half-done transfer
      st_q <= spsdr_pkg::ST_CMD;
      cnt_q <= 5'h00;
    end else if (sclk_rise) begin
      sh_in_q <= {sh_in_q[22:0], din_s[1]}; // [R7]
      cnt_q <= cnt_q + 5'h01;
      case (st_q)
        spsdr_pkg::ST_CMD: begin
          if (cnt_q == `SPSDR_CMD_LAST) begin
            cnt_q <= 5'h00;
            cmd_q <= cmd_w;
            // A set write-enable bit keeps us hunting for a command
            if (!cmd_w.wen_b)
              st_q <= cmd_w.rd ? spsdr_pkg::ST_RD : spsdr_pkg::ST_WR;
          end
        end
        spsdr_pkg::ST_WR: begin
          if (wr_end) begin
            cnt_q <= 5'h00;
            st_q <= spsdr_pkg::ST_CMD; // [R9]
          end
        end
        spsdr_pkg::ST_RD: begin
          if (rd_end) begin
            cnt_q <= 5'h00;
            st_q <= spsdr_pkg::ST_CMD; // [R9]
          end
        end
        default: st_q <= spsdr_pkg::ST_CMD;
      endcase
    end
  end

  // Output shift register: loaded at command end, shifted on falls
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sh_out_q <= 24'h000000;
    end else if (cs_act && sclk_rise && st_q == spsdr_pkg::ST_CMD &&
                 cnt_q == `SPSDR_CMD_LAST && !cmd_w.wen_b && cmd_w.rd) begin
      sh_out_q <= rd_mux; // [R6]
    end else if (sclk_fall && st_q == spsdr_pkg::ST_RD) begin
      sh_out_q <= {sh_out_q[22:0], 1'b0};
    end
  end

  // Control register writes; status and data are read-only
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < `SPSDR_NREGS; i++) regs_q[i] <= `SPSDR_CTL_RST;
    end else if (cs_act && wr_end &&
                 cmd_q.target_register_field[2:0] != `SPSDR_REG_DATA &&
                 cmd_q.target_register_field[2:0] != `SPSDR_REG_STATUS) begin
      regs_q[cmd_q.target_register_field[2:0]] <=
        {sh_in_q[14:0], din_s[1]}; // [R8]
    end
  end

  // Ready flag and data register update
  // A pending result first forces ready high for one cycle, then loads,
  // so an unread result always shows a high gap before the next one.
  // Updates wait while a read shifts, which is what fills the FIFO.
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdy_b_q <= 1'b1;
      blank_q <= 1'b0;
      data_q <= 24'h000000;
    end else begin
      if (cs_act && rd_end &&
          cmd_q.target_register_field[2:0] == `SPSDR_REG_DATA)
        rdy_b_q <= 1'b1; // Result consumed
      if (blank_q) begin
        data_q <= fifo_data.data;
        rdy_b_q <= 1'b0; // [R4]
        blank_q <= 1'b0;
      end else if (fifo_valid && st_q != spsdr_pkg::ST_RD) begin
        rdy_b_q <= 1'b1; // [R5]
        blank_q <= 1'b1;
      end
    end
  end

  // Pin flop: data bits during a read, ready indicator otherwise
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      dout_q <= 1'b1;
    end else if (st_q == spsdr_pkg::ST_RD) begin
      if (sclk_fall) dout_q <= sh_out_q[23]; // [R2]
    end else begin
      dout_q <= rdy_b_q; // [R4]
    end
  end

  assign dout_rdy_o = dout_q;
  assign dout_rdy_oe_o = cs_act; // [R3]
  assign fifo_ready = blank_q;

  // Internal oscillator model: divided core clock
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      osc_cnt_q <= 8'h00;
      osc_q <= 1'b0;
    end else if (osc_cnt_q == 8'(`SPSDR_OSC_HALF_CYC - 1)) begin
      osc_cnt_q <= 8'h00;
      osc_q <= ~osc_q;
    end else begin
      osc_cnt_q <= osc_cnt_q + 8'h01;
    end
  end

  // Clock source decode from the mode register
  assign clock_source_select_o = spsdr_pkg::spsdr_clksrc_e'(
    regs_q[`SPSDR_REG_MODE][`SPSDR_CLKSEL_LSB +: 2]); // [R1]
  assign clock_io_pin_o = osc_q;
  assign clock_io_pin_oe_o =
    (clock_source_select_o == spsdr_pkg::CLK_INT_OUT); // [R1]
  assign crystal_enable_o =
    (clock_source_select_o == spsdr_pkg::CLK_XTAL); // [R1]
  assign ext_clk_tick_o = cio_s[1] & ~cio_d1_q &
    (clock_source_select_o == spsdr_pkg::CLK_EXT); // [R1]

  spsdr_fifo #(
    .W(`SPSDR_DATA_W),
    .DEPTH(`SPSDR_FIFO_DEPTH)
  ) u_fifo (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .in_valid_i(conv_valid_i),
    .in_ready_o(conv_ready_o),
    .in_data_i(conv_i.data),
    .out_valid_o(fifo_valid),
    .out_ready_i(fifo_ready),
    .out_data_o(fifo_data.data)
  );

  default clocking ast_cb @(posedge core_clk_i); // Checks on core clock
  endclocking
  default disable iff (!rst_b_i);
  AST_OE_CS: assert property ( // [R3]
    $past(cs_b_i, 2) |-> !dout_rdy_oe_o)
    else $error("output driven while deselected");
  AST_DOUT_FALL: assert property ( // [R2]
    (st_q == spsdr_pkg::ST_RD && $past(st_q) == spsdr_pkg::ST_RD &&
     dout_rdy_o != $past(dout_rdy_o)) |-> $past(sclk_fall))
    else $error("read bit changed off a falling edge");
  AST_RDY_OUT: assert property ( // [R4]
    ($past(st_q) != spsdr_pkg::ST_RD) |-> dout_rdy_o == $past(rdy_b_q))
    else $error("idle output does not follow ready");
  AST_RDY_GAP: assert property ( // [R5]
    (fifo_valid && !blank_q && st_q != spsdr_pkg::ST_RD)
      |=> rdy_b_q ##1 (!rdy_b_q && data_q == $past(fifo_data.data)))
    else $error("no high gap before result update");
  AST_RD_LOAD: assert property ( // [R6]
    (cs_act && sclk_rise && st_q == spsdr_pkg::ST_CMD &&
     cnt_q == `SPSDR_CMD_LAST && !cmd_w.wen_b && cmd_w.rd)
      |=> (st_q == spsdr_pkg::ST_RD && sh_out_q == $past(rd_mux)))
    else $error("read shift register not loaded");
  AST_DIN_RISE: assert property ( // [R7]
    (cs_act && sclk_rise) |=> sh_in_q[0] == $past(din_s[1]))
    else $error("input bit not captured on rise");
  AST_WR_STORE: assert property ( // [R8]
    (cs_act && wr_end && cmd_q.target_register_field[2:0] == `SPSDR_REG_MODE)
      |=> regs_q[`SPSDR_REG_MODE] == $past({sh_in_q[14:0], din_s[1]}))
    else $error("written word not stored");
  AST_THREE_WIRE: assert property ( // [R9]
    (cs_act && (wr_end || rd_end))
      |=> (st_q == spsdr_pkg::ST_CMD && cnt_q == 5'h00))
    else $error("engine not back at command phase");
  AST_XTAL: assert property ( // [R1]
    (clock_source_select_o == spsdr_pkg::CLK_XTAL)
      |-> (crystal_enable_o && !clock_io_pin_oe_o && !ext_clk_tick_o))
    else $error("crystal choice drives the clock pin");
endmodule : spsdr_top

/* File: bench/spsdr_host.sv */
// Host serial port model: select, serial clock, data in, samples data out
`timescale 1ns/1ps
module spsdr_host (
  input wire logic core_clk_i,
  input wire logic dout_pin_i,
  output logic sclk_o,
  output logic cs_b_o,
  output logic din_o
);
  // Serial clock idles high and stands still between frames
  initial begin
    sclk_o = 1'b1;
    cs_b_o = 1'b1;
    din_o = 1'b0;
  end

  // One frame of n bits, MSB first; hold leaves select low (3-wire use)
  task automatic xfer(input int n, input logic [39:0] tx,
                      input logic hold, output logic [39:0] rx);
    rx = '0;
    @(negedge core_clk_i);
    cs_b_o = 1'b0;
    // Synced select needs a few core edges before the first clock edge
    repeat (4) @(negedge core_clk_i);
    for (int i = n - 1; i >= 0; i--) begin
      sclk_o = 1'b0;
      din_o = tx[i]; // Set on the fall, stable over the rise
      repeat (4) @(negedge core_clk_i);
      rx = {rx[38:0], dout_pin_i}; // Sampled at the rising edge
      sclk_o = 1'b1;
      repeat (4) @(negedge core_clk_i);
    end
    // Released line shows no stale bit: flip it
    din_o = ~din_o;
    repeat (2) @(negedge core_clk_i);
    if (!hold) begin // Select may stay low for three wires
      cs_b_o = 1'b1;
    end
    repeat (4) @(negedge core_clk_i);
  endtask : xfer
endmodule : spsdr_host

/* File: bench/testbench.sv */
// Self-checking bench for the serial port with data ready
`timescale 1ns/1ps
module testbench;
  logic core_clk, rst_b, conv_valid, ext_clk;
  logic dout, dout_oe, ck_o, ck_oe, xtal_en, tick, conv_ready;
  spsdr_pkg::spsdr_conv_s conv;
  spsdr_pkg::spsdr_clksrc_e clk_sel;
  wire sclk, cs_b, din, dout_pin, clk_pin;
  int num_errors = 0;
  int check_count = 0;
  logic [39:0] rx;
  // Shared pin levels from the device's output enables
  assign dout_pin = dout_oe ? dout : 1'bz;
  assign clk_pin = ck_oe ? ck_o : ext_clk;

  spsdr_top u_spsdr_top (.core_clk_i(core_clk), .rst_b_i(rst_b),
    .sclk_i(sclk), .cs_b_i(cs_b), .din_i(din), .dout_rdy_o(dout),
    .dout_rdy_oe_o(dout_oe), .clock_io_pin_i(clk_pin),
    .clock_io_pin_o(ck_o), .clock_io_pin_oe_o(ck_oe),
    .crystal_enable_o(xtal_en), .clock_source_select_o(clk_sel),
    .ext_clk_tick_o(tick), .conv_valid_i(conv_valid),
    .conv_ready_o(conv_ready), .conv_i(conv));
  spsdr_host u_spsdr_host (.core_clk_i(core_clk), .dout_pin_i(dout_pin),
    .sclk_o(sclk), .cs_b_o(cs_b), .din_o(din));

  // Core clock, 100 ns period
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task automatic chk(input string nm, input logic [39:0] seen,
                     input logic [39:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic summarize();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : summarize

  // One result word into the stream
  task automatic push(input logic [23:0] w);
    @(negedge core_clk);
    conv.data = w;
    conv_valid = 1'b1;
    @(negedge core_clk);
    conv_valid = 1'b0;
    repeat (6) @(negedge core_clk);
  endtask : push

  task automatic t_reset();
    chk("oe idle", 40'(dout_oe), 40'h0);
    chk("sel rst", 40'(clk_sel), 40'(spsdr_pkg::CLK_INT));
    chk("xtal rst", 40'(xtal_en), 40'h0);
  endtask : t_reset

  // All clock sources, select held low until the end of the last mode read
  task automatic t_clksel();
    int cnt;
    int tk;
    logic prev;
    for (int v = 0; v < 4; v++) begin
      u_spsdr_host.xfer(24, {24'h01, 12'h0, 2'(v), 2'h0}, 1'b1, rx);
      repeat (2) @(negedge core_clk);
      chk("sel", 40'(clk_sel), 40'(v));
      chk("xtal", 40'(xtal_en), 40'(v == 3));
      chk("ckoe", 40'(ck_oe), 40'(v == 1));
      if (v == 1) begin
        // Oscillator toggles every 4 core cycles: 4 rises in 32 cycles
        cnt = 0;
        tk = 0;
        prev = clk_pin;
        repeat (32) begin
          @(negedge core_clk);
          cnt += int'(clk_pin && !prev);
          tk += int'(tick);
          prev = clk_pin;
        end
        chk("osc", 40'(cnt), 40'd4);
        chk("no tick", 40'(tk), 40'h0);
      end
      if (v == 2) begin
        cnt = 0;
        repeat (4) begin
          ext_clk = 1'b1;
          repeat (4) @(negedge core_clk) cnt += int'(tick);
          ext_clk = 1'b0;
          repeat (4) @(negedge core_clk) cnt += int'(tick);
        end
        chk("ticks", 40'(cnt), 40'd4);
      end
      u_spsdr_host.xfer(24, 40'h41_0000, 1'(v != 3), rx);
      chk("mode rd", 40'(rx[15:0]), 40'(v << 2));
    end
  endtask : t_clksel

  // Ready flag, status and data reads
  task automatic t_ready();
    push(24'hA5C31E);
    chk("oe desel", 40'(dout_oe), 40'h0);
    u_spsdr_host.xfer(24, 40'h40_0000, 1'b1, rx);
    chk("stat low", 40'(rx[15:0]), 40'h0);
    chk("rdy low", 40'(dout_pin), 40'h0);
    u_spsdr_host.xfer(32, 40'h44_000000, 1'b1, rx);
    chk("data", 40'(rx[23:0]), 40'hA5C31E);
    chk("rdy clr", 40'(dout_pin), 40'h1);
    u_spsdr_host.xfer(24, 40'h40_0000, 1'b0, rx);
    chk("stat hi", 40'(rx[15:0]), 40'h8000);
  endtask : t_ready

  // Unread result: flag rises before the next update
  task automatic t_update();
    logic seen_high;
    u_spsdr_host.xfer(24, 40'h40_0000, 1'b1, rx);
    push(24'h13579B);
    chk("rdy a", 40'(dout_pin), 40'h0);
    seen_high = 1'b0;
    @(negedge core_clk);
    conv.data = 24'h2468AC;
    conv_valid = 1'b1;
    @(negedge core_clk);
    conv_valid = 1'b0;
    repeat (6) @(negedge core_clk) seen_high |= (dout_pin === 1'b1);
    chk("blank", 40'(seen_high), 40'h1);
    chk("rdy b", 40'(dout_pin), 40'h0);
    u_spsdr_host.xfer(32, 40'h44_000000, 1'b0, rx);
    chk("data b", 40'(rx[23:0]), 40'h2468AC);
  endtask : t_update

  // Fill the buffer while a read stalls updates, then drain it
  task automatic t_fill();
    int acc;
    logic rdy;
    acc = 0;
    fork
      u_spsdr_host.xfer(32, 40'h44_000000, 1'b0, rx);
      begin
        repeat (80) @(negedge core_clk);
        conv_valid = 1'b1;
        repeat (12) begin
          conv.data = 24'(24'h100 + acc);
          rdy = conv_ready;
          @(negedge core_clk);
          acc += int'(rdy);
        end
        conv_valid = 1'b0;
        chk("accepted", 40'(acc), 40'd8);
        chk("full", 40'(conv_ready), 40'h0);
      end
    join
    chk("held", 40'(rx[23:0]), 40'h2468AC);
    repeat (40) @(negedge core_clk);
    chk("drained", 40'(conv_ready), 40'h1);
    u_spsdr_host.xfer(32, 40'h44_000000, 1'b0, rx);
    chk("last", 40'(rx[23:0]), 40'h107);
  endtask : t_fill

  // Main sequence: reset for two cycles, then each scenario
  initial begin
    rst_b = 1'b0;
    conv_valid = 1'b0;
    conv = '0;
    ext_clk = 1'b0;
    repeat (2) @(negedge core_clk);
    rst_b = 1'b1;
    repeat (4) @(negedge core_clk);
    t_reset();
    t_clksel();
    t_ready();
    t_update();
    t_fill();
    summarize();
  end

  // Watchdog: the scenarios need well under 10000 cycles
  initial begin
    #2000000;
    num_errors++;
    $display("BAD watchdog expired");
    summarize();
  end
endmodule : testbench
